// ### usc_core.v
// usc_core.v: serial transceiver core with ahb-lite register slave.
// assumes pins are synchronous to sys_clk_i; one slave on the bus.
//
// Overview of operation
// - enabled transmitter with nothing to send holds the line high, or low in infrared mode.
// - disabled transmitter releases the pin (output enable low).
// - sync clock pulses only on data bits; last-bit pulse optional.
// - with flow control, next data frame starts only while clear-to-send low.
// - with flow control, request-to-send low means receiver can accept.
// - bit timed by counter on the bus clock wrapping at the divisor.
// - receiver splits each bit into sixteen; divisor must be sixteen up.
// - tx and rx baud counters each cleared whenever their own side is disabled.
// - data frame: low start, data with optional parity, high stops.
// - idle frame matches data frame length, all bits high.
// - break frame: one-stop data frame plus stop bit, low before last stop.
// - word length: bit 12 picks eight or nine, bit 28 picks seven.
// - stop field: one, half, two or one and a half stop bits.
// - bit 10 enables parity, bit 9 picks odd over even.
// - parity replaces data msb on send and is checked on receive.
// - infrared pulses three sixteenths of a bit, or programmed width.
// - single-wire and smartcard modes send and receive on one pin.
// - one divisor shared, separate transmit and receive counters and enables.
// - ten flags: errors, buffer, completion, idle, break, flow events.
// - lin mode sends break as master and detects break as slave.
// - transmit shifter sends least significant bit first.
// - lin break detect of ten or eleven bits; sent break is thirteen.
// - silent address wakeup: msb set word, low nibble versus node id.
//
// Chosen here: the address map and the AHB-Lite slave port.
`include "usc_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module usc_core (
    // clock and reset
    input wire sys_clk_i,
    input wire rst_i,
    // ahb-lite slave
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output reg [31:0] hrdata_o,
    output wire hreadyout_o,
    output wire hresp_o,
    // serial pins
    input wire rx_i,
    input wire tx_i,
    output reg tx_o,
    output reg tx_oe_o,
    output reg sclk_o,
    input wire cts_n_i,
    output reg rts_n_o
);
    localparam TS_IDLE = 2'b00;
    localparam TS_START = 2'b01;
    localparam TS_DATA = 2'b10;
    localparam TS_STOP = 2'b11;
    localparam K_DATA = 2'b00;
    localparam K_IDLE = 2'b01;
    localparam K_BRK = 2'b10;
    localparam RS_IDLE = 2'b00;
    localparam RS_BUSY = 2'b01;
    localparam RS_LOW = 2'b10;

    reg [31:0] c1_q, c2_q, c3_q;
    reg [15:0] div_q;
    reg [7:0] gdiv_q;
    reg [9:0] stat_q;
    reg [8:0] tdr_q, rdr_q;
    reg dp_q, dw_q;
    reg [7:0] da_q;

    // decoded controls
    wire ue = c1_q[`USC_C1_UE];
    wire te = ue & c1_q[`USC_C1_TE];
    wire re = ue & c1_q[`USC_C1_RE];
    wire pe = c1_q[`USC_C1_PE];
    wire odd = c1_q[`USC_C1_ODD];
    wire mute = c1_q[`USC_C1_SIL];
    wire wid = c1_q[`USC_C1_WID];
    wire lin = c2_q[`USC_C2_LIN];
    wire [1:0] stp = c2_q[`USC_C2_STP_HI:`USC_C2_STP_LO];
    wire [3:0] node = c2_q[`USC_C2_ID_HI:0];
    wire irda = c3_q[`USC_C3_IRDA];
    wire txe = stat_q[`USC_S_TXE];
    wire rxf = stat_q[`USC_S_RXF];
    // word length select
    wire [3:0] nb = c1_q[`USC_C1_W7] ? `USC_NB7 :
        (c1_q[`USC_C1_WL] ? `USC_NB9 : `USC_NB8);
    wire [8:0] fmask = 9'h1ff >> (4'h9 - nb);
    wire [8:0] lmask = 9'h1ff >> (4'ha - nb);

    // bus decode: address phase, then registered data phase
    wire ap = hsel_i & htrans_i[1] & hready_i;
    wire wr = dp_q & dw_q;
    wire [7:0] aa = haddr_i[7:0];
    wire rdclr = ap & ~hwrite_i & (aa == `USC_A_DATA);
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    // sample points within a bit, in sixteenths of the divisor
    wire [19:0] m_a = {4'h0, div_q} * `USC_SMP_A;
    wire [19:0] m_b = {4'h0, div_q} * `USC_SMP_B;
    wire [19:0] m_c = {4'h0, div_q} * `USC_SMP_C;
    wire [19:0] m_ir = {4'h0, div_q} * `USC_IR_W;
    wire [15:0] p_a = m_a[19:`USC_OVS_SH];
    wire [15:0] p_b = m_b[19:`USC_OVS_SH];
    wire [15:0] p_c = m_c[19:`USC_OVS_SH];
    wire [15:0] p_ir = m_ir[19:`USC_OVS_SH];
    wire [15:0] hdiv = {1'b0, div_q[15:1]};

    // transmitter state
    reg [1:0] ts_q, kind_q;
    reg [15:0] bcnt_q;
    reg [8:0] tsh_q;
    reg [3:0] tbit_q;
    reg [2:0] hc_q;
    reg ipend_q, te_q;

    // half bits per stop setting; stop state ticks every half bit
    reg [2:0] halves;
    always @* begin
        case (stp)
            2'b00: halves = 3'h2;
            2'b01: halves = 3'h1;
            2'b10: halves = 3'h4;
            2'b11: halves = 3'h3;
            default: halves = 3'h2;
        endcase
    end
    wire [15:0] lim = (ts_q == TS_STOP) ? hdiv : div_q;
    wire btick = (bcnt_q == lim - 16'h1);
    wire cts_ok = ~c3_q[`USC_C3_CTSE] | ~cts_n_i;
    wire sbk = c1_q[`USC_C1_SBK];
    wire tgo = (ts_q == TS_IDLE) & te & ~ipend_q;
    wire brk_go = tgo & sbk;
    wire tx_load = tgo & ~sbk & ~txe & cts_ok;
    wire tx_end = (ts_q == TS_STOP) & btick & (hc_q == 3'h1);
    wire tx_done = tx_end & (kind_q == K_DATA);
    // parity replaces the top data bit
    wire par = (^(tdr_q & lmask)) ^ odd;
    wire [8:0] pbit = {8'h00, par} << (nb - 4'h1);
    wire [8:0] tword = pe ? ((tdr_q & lmask) | pbit)
        : (tdr_q & fmask);

    // tx baud counter; restarts on every frame and when disabled
    always @(posedge sys_clk_i) begin
        if (rst_i | ~te | (ts_q == TS_IDLE))
            bcnt_q <= 16'h0;
        else if (btick)
            bcnt_q <= 16'h0;
        else
            bcnt_q <= bcnt_q + 16'h1;
    end

    // transmit frame sequencer
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            ts_q <= TS_IDLE;
            kind_q <= K_DATA;
            tsh_q <= 9'h0;
            tbit_q <= 4'h0;
            hc_q <= 3'h0;
            ipend_q <= 1'b0;
            te_q <= 1'b0;
        end else begin
            te_q <= te;
            // enabling sends one idle frame; a break or data ready at the enable edge goes first
            if (te & ~te_q)
                ipend_q <= 1'b1;
            case (ts_q)
                TS_IDLE: begin
                    if (te & ipend_q) begin
                        kind_q <= K_IDLE;
                        ipend_q <= 1'b0;
                        ts_q <= TS_START;
                    end else if (brk_go) begin
                        kind_q <= K_BRK;
                        ts_q <= TS_START;
                    end else if (tx_load) begin
                        kind_q <= K_DATA;
                        tsh_q <= tword;
                        ts_q <= TS_START;
                    end
                end
                TS_START: begin
                    if (btick) begin
                        ts_q <= TS_DATA;
                        if (kind_q != K_BRK)
                            tbit_q <= nb - 4'h1;
                        else if (lin)
                            tbit_q <= `USC_LIN_BRK - 4'h2;
                        else
                            tbit_q <= nb;
                    end
                end
                TS_DATA: begin
                    if (btick) begin
                        tsh_q <= {1'b0, tsh_q[8:1]};
                        if (tbit_q == 4'h0) begin
                            ts_q <= TS_STOP;
                            hc_q <= (kind_q == K_BRK) ? 3'h2 : halves;
                        end else
                            tbit_q <= tbit_q - 4'h1;
                    end
                end
                TS_STOP: begin
                    if (btick) begin
                        if (hc_q == 3'h1)
                            ts_q <= TS_IDLE;
                        else
                            hc_q <= hc_q - 3'h1;
                    end
                end
                default: ts_q <= TS_IDLE;
            endcase
            // dropping the enable mid-frame abandons the frame
            if (~te)
                ts_q <= TS_IDLE;
        end
    end

    // line level: start low, data lsb first, stops and idle high
    reg tline;
    always @* begin
        case (ts_q)
            TS_START: tline = (kind_q == K_IDLE);
            TS_DATA: tline = (kind_q == K_IDLE) |
                ((kind_q == K_DATA) & tsh_q[0]);
            default: tline = 1'b1;
        endcase
    end
    wire [15:0] pw = c3_q[`USC_C3_IRLP] ? {8'h00, gdiv_q} : p_ir;
    wire irp = ~tline & (bcnt_q < pw) & (ts_q != TS_IDLE);
    wire ckact = c2_q[`USC_C2_CKEN] & (ts_q == TS_DATA) &
        (kind_q == K_DATA) & ((tbit_q != 4'h0) | c2_q[`USC_C2_LBP]);
    wire hb = (bcnt_q >= hdiv);

    // registered pin drivers
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            tx_o <= 1'b1;
            tx_oe_o <= 1'b0;
            sclk_o <= 1'b0;
        end else begin
            tx_o <= irda ? irp : tline;
            tx_oe_o <= te;
            sclk_o <= c2_q[`USC_C2_POL] ^
                (ckact & (c2_q[`USC_C2_PHA] ? ~hb : hb));
        end
    end

    // receiver: single-wire modes listen on the transmit pin
    wire one_pin = c3_q[`USC_C3_HALF] | c3_q[`USC_C3_SC];
    wire rin = one_pin ? tx_i : rx_i;
    reg [1:0] rs_q;
    reg [15:0] rcnt_q;
    reg [3:0] rbit_q, lowrun_q;
    reg [2:0] smp_q;
    reg [8:0] rsh_q;
    reg rprev_q, nz_q, iarm_q;
    reg [19:0] icnt_q;
    wire rtick = (rs_q != RS_IDLE) & (rcnt_q == div_q - 16'h1);
    // majority of middle samples, noise when they differ
    wire rv = (smp_q[0] & smp_q[1]) | (smp_q[0] & smp_q[2]) |
        (smp_q[1] & smp_q[2]);
    wire rnz = (smp_q != 3'b000) & (smp_q != 3'b111);
    wire fd = (rs_q == RS_BUSY) & rtick & (rbit_q == nb + 4'h1);
    wire [8:0] rword = rsh_q & fmask;
    wire isaddr = rword[nb - 4'h1];
    wire idm = isaddr & (rword[3:0] == node);
    wire acc = fd & (~mute | (wid & idm));
    wire perr = pe & ((^rword) != odd);
    wire [3:0] blim = lin ? (c2_q[`USC_C2_BLEN] ? `USC_BRK11 :
        `USC_BRK10) : nb + 4'h2;
    wire brk_ev = rtick & ~rv & (lowrun_q == blim - 4'h1);
    wire [19:0] ilen = {4'h0, div_q} * {16'h0000, nb + 4'h2};
    wire idle_ev = (rs_q == RS_IDLE) & rin & iarm_q &
        (icnt_q == ilen - 20'h1);

    // receive sequencer with sixteenth sample points
    always @(posedge sys_clk_i) begin
        if (rst_i | ~re) begin
            rs_q <= RS_IDLE;
            rcnt_q <= 16'h0;
            rbit_q <= 4'h0;
            lowrun_q <= 4'h0;
            smp_q <= 3'h7;
            rsh_q <= 9'h0;
            rprev_q <= 1'b1;
            nz_q <= 1'b0;
            iarm_q <= 1'b0;
            icnt_q <= 20'h0;
        end else begin
            rprev_q <= rin;
            icnt_q <= ((rs_q != RS_IDLE) | ~rin) ? 20'h0 :
                ((icnt_q == ilen) ? icnt_q : icnt_q + 20'h1);
            if (fd)
                iarm_q <= 1'b1;
            else if (idle_ev)
                iarm_q <= 1'b0;
            if (rs_q == RS_IDLE) begin
                if (rprev_q & ~rin) begin
                    rs_q <= RS_BUSY;
                    rcnt_q <= 16'h0;
                    rbit_q <= 4'h0;
                    nz_q <= 1'b0;
                    lowrun_q <= 4'h0;
                end
            end else begin
                rcnt_q <= rtick ? 16'h0 : rcnt_q + 16'h1;
                if (rcnt_q == p_a)
                    smp_q[0] <= rin;
                if (rcnt_q == p_b)
                    smp_q[1] <= rin;
                if (rcnt_q == p_c)
                    smp_q[2] <= rin;
                if (rtick) begin
                    nz_q <= nz_q | rnz;
                    lowrun_q <= rv ? 4'h0 : ((lowrun_q == 4'hf) ?
                        lowrun_q : lowrun_q + 4'h1);
                    if (rs_q == RS_LOW) begin
                        // line still low: keep timing a long break
                        if (rv)
                            rs_q <= RS_IDLE;
                    end else if (rbit_q == 4'h0) begin
                        if (rv)
                            rs_q <= RS_IDLE; // false start
                        else
                            rbit_q <= 4'h1;
                    end else if (rbit_q <= nb) begin
                        rsh_q[rbit_q - 4'h1] <= rv;
                        rbit_q <= rbit_q + 4'h1;
                    end else
                        rs_q <= rv ? RS_IDLE : RS_LOW;
                end
            end
        end
    end

    // status flag events; hardware set wins over software clear, except a data write clearing TC and TXE wins
    reg [9:0] ev;
    reg cts_p_q;
    always @* begin
        ev = 10'h000;
        ev[`USC_S_PE] = acc & perr;
        ev[`USC_S_FE] = acc & ~rv;
        ev[`USC_S_NE] = acc & (nz_q | rnz);
        ev[`USC_S_ORE] = acc & rxf & ~rdclr;
        ev[`USC_S_IDLE] = idle_ev;
        ev[`USC_S_TC] = tx_done & txe;
        ev[`USC_S_BRK] = brk_ev;
        ev[`USC_S_CTS] = c3_q[`USC_C3_CTSE] & (cts_n_i ^ cts_p_q);
    end
    wire wstat = wr & (da_q == `USC_A_STAT);
    wire wdata = wr & (da_q == `USC_A_DATA);
    wire [9:0] clr = wstat ? (hwdata_i[9:0] & `USC_W1C) : 10'h000;
    wire store = acc & (~rxf | rdclr);

    // status, data and buffer flags
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            stat_q <= `USC_STAT_RST;
            tdr_q <= 9'h0;
            rdr_q <= 9'h0;
            cts_p_q <= 1'b1;
        end else begin
            cts_p_q <= cts_n_i;
            stat_q <= (stat_q & ~clr) | ev;
            // buffer flags follow the data path, not software
            stat_q[`USC_S_RXF] <= store | (rxf & ~rdclr);
            if (wdata) begin
                tdr_q <= hwdata_i[8:0];
                stat_q[`USC_S_TXE] <= 1'b0;
                stat_q[`USC_S_TC] <= 1'b0;
            end else if (tx_load)
                stat_q[`USC_S_TXE] <= 1'b1;
            if (store)
                rdr_q <= rword;
        end
    end

    // control registers; break request and mute self-clear
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            c1_q <= `USC_REG_RST;
            c2_q <= `USC_REG_RST;
            c3_q <= `USC_REG_RST;
            div_q <= `USC_RST16;
            gdiv_q <= `USC_RST8;
        end else begin
            if (wr & (da_q == `USC_A_CTL1))
                c1_q <= hwdata_i;
            else begin
                if (brk_go)
                    c1_q[`USC_C1_SBK] <= 1'b0;
                if (fd & wid & isaddr)
                    c1_q[`USC_C1_SIL] <= ~idm;
                else if (idle_ev & ~wid)
                    c1_q[`USC_C1_SIL] <= 1'b0;
            end
            if (wr & (da_q == `USC_A_CTL2))
                c2_q <= hwdata_i;
            if (wr & (da_q == `USC_A_CTL3))
                c3_q <= hwdata_i;
            // divisor is trusted stable while the block runs
            if (wr & (da_q == `USC_A_BAUD))
                div_q <= hwdata_i[15:0];
            if (wr & (da_q == `USC_A_GDIV))
                gdiv_q <= hwdata_i[7:0];
        end
    end

    // request-to-send: low while the receive buffer has room
    always @(posedge sys_clk_i) begin
        if (rst_i)
            rts_n_o <= 1'b1;
        else
            rts_n_o <= ~(c3_q[`USC_C3_RTSE] & re & ~rxf);
    end

    // bus phases; read data sampled at the address phase edge
    reg [31:0] rval;
    always @* begin
        case (aa)
            `USC_A_STAT: rval = {22'h0, stat_q};
            `USC_A_DATA: rval = {23'h0, rdr_q};
            `USC_A_BAUD: rval = {16'h0, div_q};
            `USC_A_CTL1: rval = c1_q;
            `USC_A_CTL2: rval = c2_q;
            `USC_A_CTL3: rval = c3_q;
            `USC_A_GDIV: rval = {24'h0, gdiv_q};
            default: rval = 32'h0;
        endcase
    end
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            dp_q <= 1'b0;
            dw_q <= 1'b0;
            da_q <= 8'h0;
            hrdata_o <= 32'h0;
        end else begin
            dp_q <= ap;
            dw_q <= ap & hwrite_i;
            da_q <= aa;
            hrdata_o <= (ap & ~hwrite_i) ? rval : 32'h0;
        end
    end
endmodule // usc_core
`default_nettype wire

// ### usc_consts.vh
// usc_consts.vh: register map, field positions and timing for usc_core.
// assumes a 32-bit ahb-lite bus, one register per aligned word.
`ifndef USC_CONSTS_VH
`define USC_CONSTS_VH
// register byte offsets
`define USC_A_STAT 8'h00
`define USC_A_DATA 8'h04
`define USC_A_BAUD 8'h08
`define USC_A_CTL1 8'h0c
`define USC_A_CTL2 8'h10
`define USC_A_CTL3 8'h14
`define USC_A_GDIV 8'h18
// control_one_reg fields
`define USC_C1_UE 13
`define USC_C1_WL 12
`define USC_C1_W7 28
`define USC_C1_WID 11
`define USC_C1_PE 10
`define USC_C1_ODD 9
`define USC_C1_TE 3
`define USC_C1_RE 2
`define USC_C1_SIL 1
`define USC_C1_SBK 0
// control_two_reg fields
`define USC_C2_LIN 14
`define USC_C2_STP_HI 13
`define USC_C2_STP_LO 12
`define USC_C2_CKEN 11
`define USC_C2_POL 10
`define USC_C2_PHA 9
`define USC_C2_LBP 8
`define USC_C2_BLEN 5
`define USC_C2_ID_HI 3
// control three fields
`define USC_C3_CTSE 9
`define USC_C3_RTSE 8
`define USC_C3_SC 5
`define USC_C3_HALF 3
`define USC_C3_IRLP 2
`define USC_C3_IRDA 1
// status bits
`define USC_S_PE 0
`define USC_S_FE 1
`define USC_S_NE 2
`define USC_S_ORE 3
`define USC_S_IDLE 4
`define USC_S_RXF 5
`define USC_S_TC 6
`define USC_S_TXE 7
`define USC_S_BRK 8
`define USC_S_CTS 9
`define USC_W1C 10'h35f
`define USC_STAT_RST 10'h080
`define USC_REG_RST 32'h0000_0000
`define USC_RST16 16'h0000
`define USC_RST8 8'h00
// word lengths and break lengths in bit times
`define USC_NB7 4'h7
`define USC_NB8 4'h8
`define USC_NB9 4'h9
`define USC_LIN_BRK 4'hd
`define USC_BRK10 4'ha
`define USC_BRK11 4'hb
// oversampling: sixteenths of a bit
`define USC_OVS_SH 4
`define USC_SMP_A 20'h00007
`define USC_SMP_B 20'h00008
`define USC_SMP_C 20'h00009
`define USC_IR_W 20'h00003
`endif

// ### usc_core_chk.sv
// usc_core_chk.sv: port assertions for usc_core.
// assumes divisor 16; cts high only with flow control on.
`timescale 1ns/10ps
`default_nettype none
module usc_chk (
    // clock, reset, bus
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    // serial pins
    input wire logic tx_o,
    input wire logic tx_oe_o,
    input wire logic sclk_o,
    input wire logic cts_n_i,
    input wire logic rts_n_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    localparam int DIV = 16;
    logic [8:0] low_q;
    wire rd = hsel_i && htrans_i[1] && !hwrite_i && hreadyout_o;
    // running low stretch on the line
    always @(posedge sys_clk_i) begin
        low_q <= (rst_i || tx_o) ? 9'h0 : low_q + 9'h1;
    end
    property p_rst;
        $fell(rst_i) |-> tx_o && !tx_oe_o && rts_n_o;
    endproperty
    a_rst: assert property (p_rst) else $error("pins wrong after reset");
    property p_idle;
        $rose(tx_oe_o) |-> tx_o [*8];
    endproperty
    a_idle: assert property (p_idle) else $error("line not idle high");
    // a reset cuts the stretch short
    property p_min;
        $rose(tx_o) && tx_oe_o && !$past(rst_i) |-> low_q >= 9'd16;
    endproperty
    a_min: assert property (p_min) else $error("bit under 16 clocks");
    property p_bitlen;
        $rose(tx_o) && tx_oe_o && !$past(rst_i) |-> low_q % DIV == 0;
    endproperty
    a_bitlen: assert property (p_bitlen) else $error("bit length off");
    property p_brkmax;
        tx_oe_o |-> low_q <= 9'd208;
    endproperty
    a_brkmax: assert property (p_brkmax) else $error("line low too long");
    property p_cts;
        cts_n_i [*4] ##0 (tx_o && tx_oe_o) |=> tx_o;
    endproperty
    a_cts: assert property (p_cts) else $error("frame while cts high");
    property p_rd0;
        !rd |=> hrdata_o == 32'h0;
    endproperty
    a_rd0: assert property (p_rd0) else $error("read data leaks");
    property p_unmap;
        rd && haddr_i[7:0] > 8'h18 |=> hrdata_o == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not 0");
    c_brk: cover property (low_q == 9'd208);
    c_cts: cover property (cts_n_i && tx_oe_o);
    c_sclk: cover property ($rose(sclk_o));
    c_rts: cover property ($fell(rts_n_o));
endmodule // usc_chk
bind usc_core usc_chk u_chk (.sys_clk_i, .rst_i, .hsel_i, .haddr_i,
    .htrans_i, .hwrite_i, .hrdata_o, .hreadyout_o, .tx_o, .tx_oe_o,
    .sclk_o, .cts_n_i, .rts_n_o);
`default_nettype wire

// ### usc_peer.sv
// usc_peer.sv: remote serial node on the core's pins.
// assumes the core clock, DIV clocks per bit.
`timescale 1ns/10ps
`default_nettype none
module usc_peer #(
    parameter int DIV = 16
) (
    // clock
    input wire logic clk_i,
    // serial line
    input wire logic line_i,
    output logic line_o
);
    // idle high between frames
    initial line_o = 1'b1;
    // lsb first; bit g gets a one-clock spike at mid-bit
    task automatic send(input logic [11:0] b, input int n, g);
        for (int i = 0; i < n; i++) begin
            for (int c = 0; c < DIV; c++) begin
                line_o <= (i == g && c == DIV / 2 + 1) ? ~b[i] : b[i];
                @(posedge clk_i);
            end
        end
        line_o <= 1'b1;
    endtask
    // waits for a start edge, samples n bits mid-bit
    task automatic get(input int n, output logic [11:0] b, output logic ok);
        int k;
        b = 12'h0;
        for (k = 0; line_i !== 1'b0 && k < 4000; k++) @(posedge clk_i);
        ok = (k < 4000);
        repeat (DIV / 2) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            b[i] = line_i;
            repeat (DIV) @(posedge clk_i);
        end
    endtask
endmodule // usc_peer
`default_nettype wire

// ### tb_top.sv
// tb_top.sv: self-checking bench for usc_core.
// assumes usc_consts.vh on the include path.
`include "usc_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int DIV = 16;
    localparam logic [31:0] C1 = 32'h200c; // block, tx and rx enabled
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic cts_n = 1'b0, ok;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
    logic [11:0] f;
    int n_mismatch = 0, n_compared = 0, cyc = 0, n, hi;
    wire [31:0] hrdata;
    wire hrdy, hresp, tx, tx_oe, sclk, rts_n, rx, pin;
    // pulled up while the core lets go
    assign pin = tx_oe ? tx : 1'b1;
    always #12.5 clk = ~clk;
    usc_core dut (.sys_clk_i(clk), .rst_i(rst), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hrdy),
        .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
        .rx_i(rx), .tx_i(pin), .tx_o(tx), .tx_oe_o(tx_oe),
        .sclk_o(sclk), .cts_n_i(cts_n), .rts_n_o(rts_n));
    usc_peer #(.DIV(DIV)) peer (.clk_i(clk), .line_i(pin), .line_o(rx));
    task automatic chk(input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // single transfer; read data into r
    task automatic bus(input logic w, input logic [7:0] a, input int d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        r = hrdata;
    endtask
    task automatic wt(input int k);
        repeat (k) @(posedge clk);
    endtask
    // clocks while tx stays at v
    task automatic run(input logic v, output int k);
        for (k = 0; tx === v && k < 4000; k++) @(posedge clk);
    endtask
    task automatic t_regs;
        bus(0, `USC_A_STAT, 0);
        chk(r, 32'h80);
        chk({hrdy, hresp, tx_oe, rts_n}, 4'b1001);
        bus(1, `USC_A_BAUD, DIV);
        bus(0, `USC_A_BAUD, 0);
        chk(r, DIV);
        bus(0, 8'h1c, 0);
        chk(r, 0);
        bus(1, `USC_A_CTL1, 32'h2004);
        wt(3);
        chk(tx_oe, 1'b0);
        bus(1, `USC_A_CTL1, C1);
        wt(3);
        chk({tx_oe, tx}, 2'b11);
        wt(12 * DIV);
        $display("regs done");
    endtask
    // word lengths and parity, lsb first
    task automatic t_fmt;
        logic [31:0] cfg [6] = '{32'h0, 32'h400, 32'h600, 32'h1000,
            32'h1000_0000, 32'h1600};
        logic [8:0] w;
        logic [11:0] e;
        for (int i = 0; i < 6; i++) begin
            n = cfg[i][28] ? 7 : cfg[i][12] ? 9 : 8;
            w = 9'h1b3;
            if (cfg[i][10])
                w[n-1] = ^(w & ((9'h1 << (n - 1)) - 9'h1)) ^ cfg[i][9];
            e = {2'h0, w, 1'b0} & ((12'h1 << n + 1) - 12'h1) | 12'h1 << n + 1;
            bus(1, `USC_A_CTL1, C1 | cfg[i]);
            bus(1, `USC_A_DATA, 32'h1b3);
            peer.get(n + 2, f, ok);
            chk({ok, f}, {1'b1, e});
        end
        bus(1, `USC_A_CTL1, C1);
        $display("fmt done");
    endtask
    // back-to-back frames: gap is stop length plus one clock
    task automatic t_stop;
        int len [4] = '{DIV, DIV / 2, 2 * DIV, 3 * DIV / 2};
        for (int s = 0; s < 4; s++) begin
            bus(1, `USC_A_CTL2, s << 12);
            bus(1, `USC_A_DATA, 0);
            do bus(0, `USC_A_STAT, 0); while (r[7] !== 1'b1);
            bus(1, `USC_A_DATA, 0);
            run(1'b0, n);
            run(1'b1, hi);
            run(1'b0, n);
            chk(hi, len[s] + 1);
            chk(n, 9 * DIV);
            wt(3 * DIV);
        end
        bus(1, `USC_A_CTL2, 0);
        $display("stop done");
    endtask
    task automatic t_brk;
        for (int l = 0; l < 2; l++) begin
            bus(1, `USC_A_CTL2, l << 14);
            bus(1, `USC_A_CTL1, C1 | 32'h1);
            run(1'b1, n);
            run(1'b0, n);
            chk(n, l ? 13 * DIV : 10 * DIV);
            bus(0, `USC_A_CTL1, 0);
            chk(r, C1);
            wt(2 * DIV);
        end
        bus(1, `USC_A_CTL2, 0);
        $display("brk done");
    endtask
    task automatic t_cts;
        bus(1, `USC_A_CTL3, 32'h200);
        cts_n <= 1'b1;
        bus(1, `USC_A_DATA, 32'h3c);
        wt(20 * DIV);
        chk(tx, 1'b1);
        cts_n <= 1'b0;
        peer.get(10, f, ok);
        chk({ok, f}, {1'b1, 12'h278});
        bus(1, `USC_A_CTL3, 0);
        $display("cts done");
    endtask
    // clean, noise, parity, stop error; fl: status bit expected
    task automatic t_rx;
        logic [11:0] fr [4] = '{12'h2b4, 12'h2b4, 12'h3b4, 12'h0b4};
        int gl [4] = '{-1, 3, -1, -1};
        int fl [4] = '{5, 2, 0, 1};
        bus(1, `USC_A_CTL3, 32'h100);
        wt(2);
        chk(rts_n, 1'b0);
        for (int i = 0; i < 4; i++) begin
            bus(1, `USC_A_CTL1, i == 2 ? C1 | 32'h400 : C1);
            bus(1, `USC_A_STAT, 32'h35f);
            peer.send(fr[i], 10, gl[i]);
            wt(DIV);
            bus(0, `USC_A_STAT, 0);
            chk(r[fl[i]], 1'b1);
            bus(0, `USC_A_DATA, 0);
            if (i == 0) chk(r[7:0], 8'h5a);
        end
        bus(1, `USC_A_CTL1, C1);
        $display("rx done");
    endtask
    // clock pulses on data bits only
    task automatic t_clk;
        int e, s;
        logic p;
        for (int b = 0; b < 2; b++) begin
            bus(1, `USC_A_CTL2, 32'h800 | (b << 8));
            bus(1, `USC_A_DATA, 32'h3c);
            run(1'b1, n);
            {e, s} = 0;
            p = sclk;
            for (int c = 0; c < 11 * DIV; c++) begin
                if (sclk && !p) e++;
                if (sclk && !p && c < DIV) s++;
                p = sclk;
                @(posedge clk);
            end
            chk(e, 7 + b);
            chk(s, 0);
        end
        bus(1, `USC_A_CTL2, 0);
        $display("clk done");
    endtask
    task automatic give_verdict;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // hang guard, several times the run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        wt(2);
        rst <= 1'b0;
        wt(1);
        t_regs();
        t_fmt();
        t_stop();
        t_brk();
        t_cts();
        t_rx();
        t_clk();
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
